//--- inc/flyback_pkg.sv
// Shared constants, types and register map of the flyback fault supervisor
`default_nettype none
package flyback_pkg;
    // Clock rate and documented durations in their own units
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned RECOVERY_MS = 1200;
    localparam int unsigned LINE_LOW_MS = 54;
    localparam int unsigned LINE_GONE_MS = 100;
    localparam int unsigned RISING_MS = 14;
    localparam int unsigned FALLING_MS = 1;
    localparam int unsigned BLANK_US = 30;
    localparam int unsigned SOFTSTART_US = 1000;
    localparam int unsigned CYC_PER_MS = CLK_MHZ * 1000;
    // Register byte offsets
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'hc;
    // Control and event bit positions
    localparam int CTRL_OT_LATCH = 0;
    localparam int EV_LATCH = 0;
    localparam int EV_NONLATCH = 1;
    localparam int EV_RECOVERY = 2;
    localparam int EV_LINE_GONE = 3;
    localparam int EV_BLEED_DONE = 4;
    localparam int EV_W = 5;
    localparam logic CTRL_RESET = 1'b0;
    // Gray-coded states along startup, run, hold, bleed
    typedef enum logic [1:0] {
        ST_STARTUP = 2'b00,
        ST_RUN = 2'b01,
        ST_HOLD = 2'b11,
        ST_BLEED = 2'b10
    } state_e;
    // Comparator results from the line-sense, supply and fault pins
    typedef struct packed {
        logic lineGood;
        logic lineAboveStop;
        logic supplyOn;
        logic supplyAboveOff;
        logic supplyAboveReset;
        logic supplyOvp;
        logic abnormalOvercurrentFault;
        logic extLatch;
        logic thermal;
        logic autoRecFault;
        logic pinUpper;
        logic pinLower;
        logic pinAboveRelease;
        logic lineAbove30;
        logic lineAbove18;
        logic slopeSmall;
        logic slopeUp;
        logic slopeDown;
    } sense_s;
    // Power-stage controls
    typedef struct packed {
        logic driveEnable;
        logic chargeEnable;
        logic bleedEnable;
        logic bleedTaper;
        logic biasEnable;
    } power_s;
    // Status register layout, low bits first from the right
    typedef struct packed {
        logic softActive;
        logic otHold;
        logic recRunning;
        logic brownout;
        logic latched;
        state_e state;
    } status_s;
endpackage
`default_nettype wire

//--- logic/flyback_fault_supervisor.sv
// Fault supervisor: fault classes, restart sequencing, line removal and bleed
`timescale 1ns/10ps
`default_nettype none
module flyback_fault_supervisor
    import flyback_pkg::*;
#(
    parameter int unsigned RECOVERY_CYC = RECOVERY_MS * CYC_PER_MS,
    parameter int unsigned LINE_LOW_CYC = LINE_LOW_MS * CYC_PER_MS,
    parameter int unsigned LINE_GONE_CYC = LINE_GONE_MS * CYC_PER_MS,
    parameter int unsigned RISING_CYC = RISING_MS * CYC_PER_MS,
    parameter int unsigned FALLING_CYC = FALLING_MS * CYC_PER_MS,
    parameter int unsigned BLANK_CYC = BLANK_US * CLK_MHZ,
    parameter int unsigned SOFTSTART_CYC = SOFTSTART_US * CLK_MHZ
)(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire sense_s senseAsync,
    output power_s power,
    output logic irq,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    // Counters except the blanking pair run one below their terminal count, so each must be at least two
    if (RECOVERY_CYC < 2 || LINE_LOW_CYC < 2 || LINE_GONE_CYC < 2 || RISING_CYC < 2
        || FALLING_CYC < 2 || BLANK_CYC < 2 || SOFTSTART_CYC < 2)
    begin : bad_count
        $error("Timer counts must be at least two cycles");
    end

    sense_s syncA;
    sense_s s;
    state_e state;
    state_e next_state;
    logic [1:0] pinRaw;
    logic [1:0] pinFault;
    logic [31:0] blankCnt [2];
    logic [31:0] boCnt, goneCnt, upCnt, downCnt, recCnt, softCnt;
    logic upFire, downFire, goneEv, brownout, latched, latchEv, otEv;
    logic otHold, recRunning, recStart, nonLatch, nonLatchQ, blocked;
    logic softActive, lowArmed, otLatchSel, wbReq;
    logic [EV_W-1:0] events, irqStat, irqMask;

    // ****************************************
    // Input synchronisation
    // ****************************************
    // Two stages; only the second is read by the fault logic
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            syncA <= '0;
            s <= '0;
        end
        else if (ce)
        begin
            syncA <= senseAsync;
            s <= syncA;
        end
    end

    // ****************************************
    // Fault pin detectors
    // ****************************************
    // Lower detector is blind until bias is on and soft-start has ended
    assign lowArmed = power.biasEnable && !softActive;
    assign pinRaw = {s.pinLower && lowArmed, s.pinUpper};

    for (genvar g = 0; g < 2; g++)
    begin : blank
        // Excursions shorter than the blanking window never reach the fault
        always_ff @(posedge mclk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                blankCnt[g] <= '0;
                pinFault[g] <= 1'b0;
            end
            else if (ce)
            begin
                if (!pinRaw[g])
                begin
                    blankCnt[g] <= '0;
                    pinFault[g] <= 1'b0;
                end
                else if (blankCnt[g] >= BLANK_CYC)
                    pinFault[g] <= 1'b1;
                else
                    blankCnt[g] <= blankCnt[g] + 32'd1;
            end
        end
    end

    // ****************************************
    // Fault classification
    // ****************************************
    assign otEv = pinFault[1];
    assign latchEv = s.supplyOvp || s.abnormalOvercurrentFault || s.extLatch
        || pinFault[0] || (otEv && otLatchSel);
    assign recStart = s.autoRecFault || (otEv && !otLatchSel);
    assign nonLatch = brownout || s.thermal || otHold;
    // Any fault class, the held latch or a running recovery timer vetoes restart, with no precedence among them
    assign blocked = latchEv || latched || nonLatch || recRunning || recStart;

    // Latch survives everything but the reset level or line removal
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            latched <= 1'b0;
        else if (ce)
        begin
            if (!s.supplyAboveReset || goneEv)
                latched <= 1'b0;
            else if (latchEv)
                latched <= 1'b1;
        end
    end

    // Auto-recovery overtemperature waits for release level and timer
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            otHold <= 1'b0;
        else if (ce)
        begin
            if (otEv && !otLatchSel)
                otHold <= 1'b1;
            else if (!s.supplyAboveReset || goneEv)
                otHold <= 1'b0;
            else if (s.pinAboveRelease && !recRunning)
                otHold <= 1'b0;
        end
    end

    // Recovery timer, restarted while the fault is still present
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            recCnt <= '0;
            recRunning <= 1'b0;
        end
        else if (ce)
        begin
            if (recStart)
            begin
                recCnt <= '0;
                recRunning <= 1'b1;
            end
            else if (recRunning && recCnt == RECOVERY_CYC - 1)
                recRunning <= 1'b0;
            else if (recRunning)
                recCnt <= recCnt + 32'd1;
        end
    end

    // ****************************************
    // Brownout timer
    // ****************************************
    // A one-cycle line dropout is shorter than the timer and is ignored
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            boCnt <= '0;
            brownout <= 1'b0;
        end
        else if (ce)
        begin
            if (s.lineAboveStop)
                boCnt <= '0;
            else if (boCnt == LINE_LOW_CYC - 1)
                brownout <= 1'b1;
            else
                boCnt <= boCnt + 32'd1;
            if (s.lineGood)
                brownout <= 1'b0;
        end
    end

    // ****************************************
    // Line removal timers
    // ****************************************
    assign upFire = s.slopeUp && upCnt == RISING_CYC - 1;
    assign downFire = s.slopeDown && downCnt == FALLING_CYC - 1;
    assign goneEv = s.slopeSmall && !upFire && !downFire
        && goneCnt == LINE_GONE_CYC - 1;

    // Slope timers; each firing clears the removal timer
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            upCnt <= '0;
            downCnt <= '0;
        end
        else if (ce)
        begin
            upCnt <= (!s.slopeUp || upFire) ? '0 : upCnt + 32'd1;
            downCnt <= (!s.slopeDown || downFire) ? '0 : downCnt + 32'd1;
        end
    end

    // Removal timer runs in every state, also during bleed
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            goneCnt <= '0;
        else if (ce)
        begin
            if (upFire || downFire || goneEv)
                goneCnt <= '0;
            else if (s.slopeSmall)
                goneCnt <= goneCnt + 32'd1;
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    // Removal overrides every state; bleed only ends at the end level
    always_comb
    begin
        next_state = state;
        case (state)
            ST_STARTUP, ST_HOLD:
                if (!blocked && s.lineGood && s.supplyOn)
                    next_state = ST_RUN;
                else if (blocked)
                    next_state = ST_HOLD;
            ST_RUN:
                if (blocked || !s.supplyAboveOff)
                    next_state = ST_HOLD;
            ST_BLEED:
                if (!s.lineAbove18)
                    next_state = ST_STARTUP;
            default:
                next_state = ST_STARTUP;
        endcase
        if (goneEv)
            next_state = ST_BLEED;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            state <= ST_STARTUP;
        else if (ce)
            state <= next_state;
    end

    // Soft-start window opened at each entry to run
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            softCnt <= '0;
            softActive <= 1'b0;
        end
        else if (ce)
        begin
            if (state != ST_RUN && next_state == ST_RUN)
            begin
                softCnt <= '0;
                softActive <= 1'b1;
            end
            else if (softActive && softCnt == SOFTSTART_CYC - 1)
                softActive <= 1'b0;
            else if (softActive)
                softCnt <= softCnt + 32'd1;
        end
    end

    // ****************************************
    // Power-stage controls
    // ****************************************
    // Charging source keeps supply between stop and start while held off
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            power <= '{driveEnable: 1'b0, chargeEnable: 1'b1, bleedEnable: 1'b0,
                       bleedTaper: 1'b0, biasEnable: 1'b0};
        else if (ce)
        begin
            power.driveEnable <= next_state == ST_RUN;
            power.bleedEnable <= next_state == ST_BLEED;
            power.bleedTaper <= next_state == ST_BLEED && !s.lineAbove30;
            if (next_state == ST_BLEED || next_state == ST_RUN)
                power.chargeEnable <= 1'b0;
            else if (!s.supplyAboveOff)
                power.chargeEnable <= 1'b1;
            else if (s.supplyOn)
                power.chargeEnable <= 1'b0;
            if (!s.supplyAboveReset || next_state == ST_BLEED)
                power.biasEnable <= 1'b0;
            else if (s.supplyOn)
                power.biasEnable <= 1'b1;
        end
    end

    // ****************************************
    // Interrupts and registers
    // ****************************************
    assign events = {
        state == ST_BLEED && next_state == ST_STARTUP,
        goneEv,
        recStart && !recRunning,
        nonLatch && !nonLatchQ,
        latchEv && !latched
    };
    assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;

    // Status bits are sticky; a new event wins over a same-cycle clear
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irqStat <= '0;
            nonLatchQ <= 1'b0;
            irq <= 1'b0;
        end
        else if (ce)
        begin
            nonLatchQ <= nonLatch;
            if (wbReq && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_IRQ_STAT)
                irqStat <= (irqStat & ~wb_dat_i[EV_W-1:0]) | events;
            else
                irqStat <= irqStat | events;
            irq <= |(irqStat & irqMask);
        end
    end

    // Classic single-cycle slave: ack one cycle after the request
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
            otLatchSel <= CTRL_RESET;
            irqMask <= '0;
        end
        else if (ce)
        begin
            wb_ack_o <= wbReq;
            wb_dat_o <= '0;
            if (wbReq && wb_we_i && wb_sel_i[0])
            begin
                if (wb_adr_i == ADDR_CTRL)
                    otLatchSel <= wb_dat_i[CTRL_OT_LATCH];
                else if (wb_adr_i == ADDR_IRQ_MASK)
                    irqMask <= wb_dat_i[EV_W-1:0];
            end
            else if (wbReq && !wb_we_i)
            begin
                if (wb_adr_i == ADDR_CTRL)
                    wb_dat_o <= 32'(otLatchSel);
                else if (wb_adr_i == ADDR_STATUS)
                    wb_dat_o <= 32'(status_s'{softActive, otHold, recRunning,
                                              brownout, latched, state});
                else if (wb_adr_i == ADDR_IRQ_STAT)
                    wb_dat_o <= 32'(irqStat);
                else if (wb_adr_i == ADDR_IRQ_MASK)
                    wb_dat_o <= 32'(irqMask);
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    latch_kill_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && latchEv && s.supplyAboveReset && !goneEv |=> latched && !power.driveEnable)
        else $error("Latching fault did not stop drive");
    latch_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && latched && s.supplyAboveReset && !goneEv |=> latched)
        else $error("Latch released without reset or removal");
    latch_norun_a: assert property (@(posedge mclk) disable iff (!rst_n)
        latched |-> !power.driveEnable)
        else $error("Drive on while latched");
    hold_charge_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && state == ST_HOLD && !goneEv && !s.supplyAboveOff |=> power.chargeEnable)
        else $error("Charging source off below stop level");
    fault_restart_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && state == ST_HOLD && !blocked && s.lineGood && s.supplyOn && !goneEv
        |=> power.driveEnable)
        else $error("No restart after fault cleared");
    rec_start_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && s.autoRecFault |=> recRunning && !power.driveEnable)
        else $error("Recovery fault did not start timer");
    brownout_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && !s.lineAboveStop && !s.lineGood && boCnt == LINE_LOW_CYC - 1 |=> brownout)
        else $error("Brownout not declared at expiry");
    gone_bleed_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && goneEv |=> state == ST_BLEED && power.bleedEnable && !power.driveEnable)
        else $error("Line removal did not start bleed");
    bleed_taper_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && state == ST_BLEED && !goneEv && s.lineAbove18 && !s.lineAbove30
        |=> power.bleedTaper && power.bleedEnable)
        else $error("Bleed did not taper below 30 V");
    upper_latch_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && pinFault[0] && s.supplyAboveReset && !goneEv |=> latched)
        else $error("Upper pin fault did not latch");
    low_ignore_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && !lowArmed |=> !pinFault[1])
        else $error("Lower pin fault seen while ignored");
endmodule // flyback_fault_supervisor
`default_nettype wire

//--- tb/flyback_partner.sv
// Behavioural supply capacitor and input capacitor around the fault supervisor
`timescale 1ns/10ps
`default_nettype none
module flyback_partner
    import flyback_pkg::*;
(
    input wire logic mclk,
    input wire power_s power,
    input wire logic drain,
    input wire sense_s ext,
    output sense_s sense
);
    // ************************
    // Capacitor levels
    // ************************
    int vcc = 0;
    int hv = 50;
    // Supply charges from the line, is fed by the aux winding while switching, else decays
    always @(posedge mclk)
    begin
        if (drain) vcc <= 0;
        else if (power.chargeEnable && vcc < 40) vcc <= vcc + 1;
        else if (!power.driveEnable && !power.chargeEnable && vcc > 0) vcc <= vcc - 1;
        // Only the sink lowers the line-sense node once the line is gone
        if (ext.lineGood) hv <= 50;
        else if (power.bleedEnable && hv > 0) hv <= hv - 1;
    end
    // Comparator results seen by the supervisor
    always_comb
    begin
        sense = ext;
        sense.supplyOn = (vcc >= 30);
        sense.supplyAboveOff = (vcc > 10);
        sense.supplyAboveReset = (vcc > 3);
        sense.lineAbove30 = (hv > 30);
        sense.lineAbove18 = (hv > 18);
    end
endmodule // flyback_partner
`default_nettype wire

//--- tb/flyback_fault_supervisor_tb.sv
// Self-checking testbench of the flyback fault supervisor
`timescale 1ns/10ps
`default_nettype none
module flyback_fault_supervisor_tb
    import flyback_pkg::*;
;
    // ************************
    // Stimulus and observation
    // ************************
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic drain = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [3:0] sel = 4'h0;
    logic [3:0] selw = 4'hf; // Byte lanes of the next bus request
    logic [31:0] wdat = 32'h0;
    logic [31:0] dato;
    logic [31:0] q;
    logic ack;
    logic irq;
    sense_s ext = 18'h30020; // Line good and above stop, pin above release
    sense_s sense;
    power_s power;
    int err_count = 0;
    int comparisons = 0;
    int seed = 52;
    int n;
    int expStat; // Model of the sticky event bits
    // Clock of 5 ns
    initial
    begin
        forever #2.5 mclk = ~mclk;
    end
    flyback_fault_supervisor #(.RECOVERY_CYC(20), .LINE_LOW_CYC(16), .LINE_GONE_CYC(40),
        .RISING_CYC(8), .FALLING_CYC(4), .BLANK_CYC(5), .SOFTSTART_CYC(10))
    flyback_fault_supervisor_inst (.mclk(mclk), .rst_n(rst_n), .ce(ce), .senseAsync(sense),
        .power(power), .irq(irq), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dato), .wb_ack_o(ack));
    flyback_partner flyback_partner_inst (.mclk(mclk), .power(power), .drain(drain),
        .ext(ext), .sense(sense));
    // ************************
    // Tasks
    // ************************
    task automatic chk_reg(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk_bit(input string name, input logic exp, input logic got);
        chk_reg(name, {31'h0, exp}, {31'h0, got});
    endtask
    // Classic single cycle; holds everything until ack is sampled high
    task automatic wbx(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= selw;
        do
        begin
            @(posedge mclk);
            k++;
        end while (ack !== 1'b1 && k < 50);
        if (k >= 50)
            err_count++;
        q = dato;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic ticks(input int c);
        repeat (c) @(posedge mclk);
        #1;
    endtask
    task automatic setx(input int i, input logic v);
        @(posedge mclk);
        ext[i] <= v;
    endtask
    // Bounded wait for one power output, then compare it
    task automatic wait_pw(input string name, input int i, input logic v, input int lim);
        n = 0;
        while (power[i] !== v && n < lim)
        begin
            ticks(1);
            n++;
        end
        chk_bit(name, v, power[i]);
    endtask
    task automatic stat_chk(input int bitPos, input logic v);
        wbx(1'b0, ADDR_STATUS, 32'h0);
        chk_bit("status", v, q[bitPos]);
    endtask
    task automatic ev_chk();
        wbx(1'b0, ADDR_IRQ_STAT, 32'h0);
        chk_reg("irqStat", expStat, q);
        wbx(1'b1, ADDR_IRQ_STAT, 32'h1f);
        expStat = 0;
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Hang guard of 20000 cycles, far beyond the several hundred cycles of the tests
    initial
    begin
        #100000;
        err_count++;
        give_verdict();
    end
    // ************************
    // Test sequence
    // ************************
    initial
    begin
        ticks(2);
        chk_reg("powerInReset", 32'h8, {27'h0, power});
        chk_bit("irqInReset", 1'b0, irq);
        @(posedge mclk);
        rst_n <= 1'b1;
        wbx(1'b0, ADDR_CTRL, 32'h0);
        chk_reg("ctrl", 32'h0, q);
        wbx(1'b0, ADDR_IRQ_MASK, 32'h0);
        chk_reg("mask", 32'h0, q);
        wbx(1'b0, 4'h1 + ($random(seed) & 4'h2), 32'h0);
        chk_reg("unmapped", 32'h0, q);
        // A write without the low byte lane must leave the mask alone
        selw = 4'($random(seed)) & 4'he;
        wbx(1'b1, ADDR_IRQ_MASK, 32'h1f);
        selw = 4'hf;
        wbx(1'b0, ADDR_IRQ_MASK, 32'h0);
        chk_reg("maskNoLane", 32'h0, q);
        wbx(1'b1, ADDR_IRQ_MASK, 32'h1);
        wait_pw("driveStart", 4, 1'b1, 300);
        $display("test reset and startup done");
        // Each latching supply-overvoltage, overcurrent and external input: immediate stop, no restart, cleared here by reset level
        for (int i = 10; i <= 12; i++)
        begin
            setx(i, 1'b1);
            ticks(3);
            chk_bit("driveLatch", 1'b0, power.driveEnable);
            setx(i, 1'b0);
            ticks(80);
            chk_bit("driveStaysOff", 1'b0, power.driveEnable);
            chk_bit("irqLatch", 1'b1, irq);
            stat_chk(2, 1'b1);
            expStat = 1;
            ev_chk();
            ticks(2);
            chk_bit("irqCleared", 1'b0, irq);
            drain = 1'b1;
            ticks(5);
            drain = 1'b0;
            wait_pw("driveAfterReset", 4, 1'b1, 300);
        end
        $display("test latching faults done");
        // A pin excursion not longer than the blanking delay is ignored
        setx(7, 1'b1);
        ticks(1 + ({$random(seed)} % 4));
        setx(7, 1'b0);
        ticks(20);
        chk_bit("driveGlitch", 1'b1, power.driveEnable);
        setx(7, 1'b1);
        wait_pw("drivePinUpper", 4, 1'b0, 12);
        setx(7, 1'b0);
        expStat = 1;
        ev_chk();
        $display("test fault pin done");
        // Line removal clears the pin latch; a returning line does not stop the bleed
        setx(17, 1'b0);
        setx(2, 1'b1);
        wait_pw("bleedStart", 2, 1'b1, 60);
        chk_bit("driveBleed", 1'b0, power.driveEnable);
        setx(17, 1'b1);
        ticks(10);
        chk_bit("bleedLineBack", 1'b1, power.bleedEnable);
        setx(17, 1'b0);
        wait_pw("taper", 1, 1'b1, 60);
        wait_pw("bleedEnd", 2, 1'b0, 60);
        stat_chk(2, 1'b0);
        expStat = 32'h18;
        ev_chk();
        setx(2, 1'b0);
        setx(17, 1'b1);
        wait_pw("driveAfterBleed", 4, 1'b1, 300);
        $display("test line removal done");
        // Brownout: a dip shorter than the timer keeps running
        setx(16, 1'b0);
        setx(17, 1'b0);
        ticks(10);
        chk_bit("driveDip", 1'b1, power.driveEnable);
        wait_pw("driveBrownout", 4, 1'b0, 20);
        stat_chk(3, 1'b1);
        setx(16, 1'b1);
        setx(17, 1'b1);
        wait_pw("driveLineBack", 4, 1'b1, 300);
        stat_chk(3, 1'b0);
        $display("test brownout done");
        // Thermal shutdown, then an auto-recovery fault that must wait out its timer
        setx(9, 1'b1);
        wait_pw("driveThermal", 4, 1'b0, 6);
        setx(9, 1'b0);
        wait_pw("driveThermalEnd", 4, 1'b1, 300);
        setx(8, 1'b1);
        setx(8, 1'b0);
        wait_pw("driveRecovery", 4, 1'b0, 6);
        stat_chk(4, 1'b1);
        ticks(4);
        chk_bit("driveTimerRuns", 1'b0, power.driveEnable);
        wait_pw("driveRecovered", 4, 1'b1, 300);
        $display("test non-latching faults done");
        // Clock enable low freezes the supervisor; a fault acts only once it returns
        @(posedge mclk);
        ce <= 1'b0;
        setx(9, 1'b1);
        ticks(10);
        chk_bit("driveFrozen", 1'b1, power.driveEnable);
        @(posedge mclk);
        ce <= 1'b1;
        wait_pw("driveThawed", 4, 1'b0, 6);
        setx(9, 1'b0);
        $display("test clock enable done");
        give_verdict();
    end
endmodule // flyback_fault_supervisor_tb
`default_nettype wire
